// file: hw/fsd_core.sv
// How it works
// - decimal add runs as add-with-skip 6, add-with-carry at HL, add-with-skip 10.
// - a true skip condition discards the next instruction and runs the one after.
// - a skip costs exactly one extra machine cycle, none when no skip.
// - one machine cycle is one CPU clock period, chosen from three rates.
// - A is the nibble accumulator, XA the byte pair, HL the data pointer.
// - immediates are 4 or 8 bits wide, bit selects are 2 bits.
// - special bit addressing reaches only FB0H-FBFH and FF0H-FFFH in bank 15.
// - byte memory operands need an even address and use the next odd nibble.
// - absolute program targets are 11 bits and limited to 000H-77FH.
// - direct data reaches 00H-3FH in bank 0 and 80H-FFH in bank 15.
// - relative branch reaches 15 to 1 below or 2 to 16 above the PC.
// - carry acts as bit accumulator for AND, OR and XOR with a memory bit.
// - port operands select ports 0-3, 5 and 6 only, never port 4.
// - interrupt enable operands name exactly four enable flags.
// - carry from add-with-carry skips the next add-with-skip, which never skips.
`timescale 1ns/100ps
`include "fsd_defines.svh"

module fsd_core (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [1:0] processor_clock_control_in,
   input wire logic instr_valid_in,
   input wire fsd_pkg::fsd_instr_t instr_in,
   input wire logic [23:0] port_pins_in,
   output logic instr_ready_out,
   output fsd_pkg::fsd_regs_t regs_out,
   output logic [10:0] pc_out,
   output logic [3:0] ie_flags_out,
   output logic [23:0] port_latch_out,
   output logic skip_pending_out,
   output logic operand_fault_out,
   output logic cycle_tick_out
);

   ////////////////////////////////////////////////////////////////////////
   // Address and operand checks used by several instructions

   function automatic logic mem_ok(input logic [11:0] ad);
      mem_ok = (ad[11:8] == `FSD_BANK0 && ad[7:0] <= `FSD_B0_TOP) ||
               (ad[11:8] == `FSD_BANK15 && ad[7:0] >= `FSD_B15_BASE);
   endfunction

   function automatic logic [7:0] mem_index(input logic [11:0] ad);
      mem_index = (ad[11:8] == `FSD_BANK0) ? {2'h0, ad[5:0]} :
                  ({1'b0, ad[6:0]} + `FSD_B15_OFS);
   endfunction

   function automatic logic fmem_ok(input logic [11:0] ad);
      fmem_ok = ad[11:8] == `FSD_BANK15 &&
                (ad[7:4] == `FSD_FMEM_ROW_A || ad[7:4] == `FSD_FMEM_ROW_B);
   endfunction

   function automatic logic port_ok(input logic [2:0] p);
      port_ok = p != `FSD_PORT_GAP && p <= `FSD_PORT_TOP;
   endfunction

   // Ports 5 and 6 close the gap so the latch vector has no dead nibble
   function automatic logic [2:0] port_index(input logic [2:0] p);
      port_index = (p > `FSD_PORT_LOW_TOP) ? p - 3'h1 : p;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // State

   typedef enum logic {ST_IDLE, ST_RUN} fsd_state_t;

   fsd_state_t state_reg;
   fsd_pkg::fsd_instr_t cur_reg;
   fsd_pkg::fsd_regs_t regs_reg;
   fsd_pkg::fsd_regs_t regs_next;
   logic [10:0] pc_reg;
   logic [10:0] pc_next;
   logic [3:0] ie_reg;
   logic [3:0] ie_next;
   logic [23:0] latch_reg;
   logic [23:0] latch_next;
   logic [3:0] div_cnt_reg;
   logic [1:0] left_reg;
   logic skip_cur_reg;
   logic skip_pend_reg;
   logic skip_next;
   logic inhibit_reg;
   logic inhibit_next;
   logic fault_reg;
   logic fault_next;
   logic [23:0] pins_meta_reg;
   logic [23:0] pins_sync_reg;
   logic [3:0] mem_reg [0:`FSD_MEM_WORDS-1];
   logic mem_we;
   logic [7:0] mem_widx;
   logic [3:0] mem_wdata;

   ////////////////////////////////////////////////////////////////////////
   // Decode of the held instruction

   wire logic tick = div_cnt_reg == 4'h0;
   wire logic [3:0] div_load =
      (processor_clock_control_in == `FSD_PCC_CODE0) ? `FSD_DIV_CODE0 - 4'h1 :
      (processor_clock_control_in == `FSD_PCC_CODE1) ? `FSD_DIV_CODE1 - 4'h1 :
      `FSD_DIV_CODE2 - 4'h1;
   wire logic accept = state_reg == ST_IDLE && instr_valid_in;
   wire logic commit = state_reg == ST_RUN && tick && left_reg == 2'h1;
   wire logic [3:0] mb = regs_reg.memory_bank_select;
   wire logic [11:0] dir_ad = {mb, cur_reg.addr[7:0]};
   wire logic [11:0] dir_ad1 = {mb, cur_reg.addr[7:1], 1'b1};
   wire logic [11:0] hl_ad = {mb, regs_reg.h, regs_reg.l};
   wire logic dir_ok = mem_ok(dir_ad);
   wire logic f_ok = fmem_ok(cur_reg.addr);
   wire logic hl_ok = mem_ok(hl_ad);
   wire logic [3:0] dir_rd = mem_reg[mem_index(dir_ad)];
   wire logic [3:0] dir_rd1 = mem_reg[mem_index(dir_ad1)];
   wire logic [3:0] hl_rd = mem_reg[mem_index(hl_ad)];
   wire logic [3:0] f_rd = mem_reg[mem_index(cur_reg.addr)];
   wire logic f_bit = f_rd[cur_reg.bit_sel];
   wire logic [3:0] f_mask = 4'h1 << cur_reg.bit_sel;
   wire logic [4:0] add_immediate_with_skip_sum = {1'b0, regs_reg.a} + {1'b0, cur_reg.imm[3:0]};
   wire logic [4:0] add_with_carry_op_sum = {1'b0, regs_reg.a} + {1'b0, hl_rd} +
                               {4'h0, regs_reg.carry_flag};
   wire logic [10:0] pc_step = pc_reg + {9'h000, cur_reg.bytes};
   wire logic [10:0] pc_rel = pc_reg + {{3{cur_reg.imm[7]}}, cur_reg.imm};
   wire logic rel_ok = cur_reg.imm >= `FSD_REL_NEG_MIN ||
      (cur_reg.imm >= `FSD_REL_POS_MIN &&
       cur_reg.imm <= `FSD_REL_POS_MAX);
   wire logic p_ok = port_ok(cur_reg.port);
   wire logic [4:0] p_lsb = {port_index(cur_reg.port), 2'h0};
   // Skipped instruction costs exactly one cycle
   wire logic [1:0] left_init = (skip_pend_reg || instr_in.bytes == 2'h0) ?
      `FSD_SKIP_CYCLES : instr_in.bytes;

   ////////////////////////////////////////////////////////////////////////
   // Execution: next architectural state at the last machine cycle

   always_comb
   begin
      regs_next = regs_reg;
      pc_next = pc_step;
      ie_next = ie_reg;
      latch_next = latch_reg;
      skip_next = 1'b0;
      inhibit_next = 1'b0;
      fault_next = 1'b0;
      mem_we = 1'b0;
      mem_widx = mem_index(cur_reg.addr);
      mem_wdata = f_rd;
      // A discarded instruction only moves the PC past its bytes
      if (!skip_cur_reg)
      begin
         case (cur_reg.op)
            fsd_pkg::OP_MOV_A: regs_next.a = cur_reg.imm[3:0];
            fsd_pkg::OP_MOV_XA: {regs_next.x, regs_next.a} = cur_reg.imm;
            fsd_pkg::OP_MOV_HL: {regs_next.h, regs_next.l} = cur_reg.imm;
            fsd_pkg::OP_SEL_MB: regs_next.memory_bank_select = cur_reg.imm[3:0];
            fsd_pkg::OP_ADD_IMMEDIATE_WITH_SKIP:
            begin
               // Carry untouched; skip only outside a correction pair
               regs_next.a = add_immediate_with_skip_sum[3:0];
               skip_next = add_immediate_with_skip_sum[4] && !inhibit_reg;
            end
            fsd_pkg::OP_ADD_WITH_CARRY_OP:
            begin
               regs_next.a = add_with_carry_op_sum[3:0];
               regs_next.carry_flag = add_with_carry_op_sum[4];
               skip_next = add_with_carry_op_sum[4];
               inhibit_next = 1'b1;
               fault_next = !hl_ok;
            end
            fsd_pkg::OP_LD_A:
               if (dir_ok) regs_next.a = dir_rd;
               else fault_next = 1'b1;
            fsd_pkg::OP_ST_A:
               if (dir_ok)
               begin
                  mem_we = 1'b1;
                  mem_widx = mem_index(dir_ad);
                  mem_wdata = regs_reg.a;
               end
               else fault_next = 1'b1;
            fsd_pkg::OP_LD_XA:
               // Byte operand: even nibble to A, odd neighbour to X
               if (dir_ok && !cur_reg.addr[0])
               begin
                  regs_next.a = dir_rd;
                  regs_next.x = dir_rd1;
               end
               else fault_next = 1'b1;
            fsd_pkg::OP_SET1, fsd_pkg::OP_CLR1:
               if (f_ok)
               begin
                  mem_we = 1'b1;
                  mem_wdata = (cur_reg.op == fsd_pkg::OP_SET1) ?
                     (f_rd | f_mask) : (f_rd & ~f_mask);
               end
               else fault_next = 1'b1;
            fsd_pkg::OP_SKT:
               if (f_ok) skip_next = f_bit;
               else fault_next = 1'b1;
            fsd_pkg::OP_SKF:
               if (f_ok) skip_next = !f_bit;
               else fault_next = 1'b1;
            fsd_pkg::OP_AND1, fsd_pkg::OP_OR1, fsd_pkg::OP_XOR1:
               if (!f_ok) fault_next = 1'b1;
               else if (cur_reg.op == fsd_pkg::OP_AND1)
                  regs_next.carry_flag = regs_reg.carry_flag & f_bit;
               else if (cur_reg.op == fsd_pkg::OP_OR1)
                  regs_next.carry_flag = regs_reg.carry_flag | f_bit;
               else
                  regs_next.carry_flag = regs_reg.carry_flag ^ f_bit;
            fsd_pkg::OP_OUT:
               if (p_ok) latch_next[p_lsb +: 4] = regs_reg.a;
               else fault_next = 1'b1;
            fsd_pkg::OP_IN:
               if (p_ok) regs_next.a = pins_sync_reg[p_lsb +: 4];
               else fault_next = 1'b1;
            fsd_pkg::OP_EI: ie_next[cur_reg.ie_sel] = 1'b1;
            fsd_pkg::OP_DI: ie_next[cur_reg.ie_sel] = 1'b0;
            fsd_pkg::OP_JMP:
               if (cur_reg.target <= `FSD_PROG_TOP) pc_next = cur_reg.target;
               else fault_next = 1'b1;
            fsd_pkg::OP_BR:
               if (rel_ok) pc_next = pc_rel;
               else fault_next = 1'b1;
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Machine cycle divider; reload uses the rate in force at each tick

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in) div_cnt_reg <= 4'h0;
      else if (tick) div_cnt_reg <= div_load;
      else div_cnt_reg <= div_cnt_reg - 4'h1;
   end

   // Port pins come from outside, so two flops before any use
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         pins_meta_reg <= 24'h000000;
         pins_sync_reg <= 24'h000000;
      end
      else
      begin
         pins_meta_reg <= port_pins_in;
         pins_sync_reg <= pins_meta_reg;
      end
   end

   // Sequencer: take one instruction, count its machine cycles, commit
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         state_reg <= ST_IDLE;
         cur_reg <= '0;
         left_reg <= 2'h0;
         skip_cur_reg <= 1'b0;
      end
      else
      begin
         case (state_reg)
            ST_IDLE:
               if (accept)
               begin
                  cur_reg <= instr_in;
                  skip_cur_reg <= skip_pend_reg;
                  left_reg <= left_init;
                  state_reg <= ST_RUN;
               end
            ST_RUN:
               if (commit) state_reg <= ST_IDLE;
               else if (tick) left_reg <= left_reg - 2'h1;
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // Architectural state moves only at commit
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         regs_reg <= '0;
         pc_reg <= 11'h000;
         ie_reg <= 4'h0;
         latch_reg <= 24'h000000;
         skip_pend_reg <= 1'b0;
         inhibit_reg <= 1'b0;
         fault_reg <= 1'b0;
      end
      else
      begin
         fault_reg <= commit && fault_next;
         if (commit)
         begin
            regs_reg <= regs_next;
            pc_reg <= pc_next;
            ie_reg <= ie_next;
            latch_reg <= latch_next;
            skip_pend_reg <= skip_next;
            inhibit_reg <= inhibit_next;
         end
      end
   end

   // Data memory has no reset: contents are undefined until written
   always_ff @(posedge clk_in)
   begin
      if (commit && mem_we) mem_reg[mem_widx] <= mem_wdata;
   end

   assign instr_ready_out = state_reg == ST_IDLE;
   assign regs_out = regs_reg;
   assign pc_out = pc_reg;
   assign ie_flags_out = ie_reg;
   assign port_latch_out = latch_reg;
   assign skip_pending_out = skip_pend_reg;
   assign operand_fault_out = fault_reg;
   assign cycle_tick_out = tick;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   property p_skip_quiet;
      @(posedge clk_in) disable iff (rst_in)
      commit && skip_cur_reg |=> regs_out == $past(regs_out) &&
         port_latch_out == $past(port_latch_out) && !operand_fault_out;
   endproperty
   a_skip_quiet: assert property (p_skip_quiet)
      else $error("skipped instruction changed state");

   property p_skip_pc;
      @(posedge clk_in) disable iff (rst_in)
      commit && skip_cur_reg |=> pc_out == $past(pc_step);
   endproperty
   a_skip_pc: assert property (p_skip_pc)
      else $error("skipped instruction bytes not passed");

   property p_skip_one;
      @(posedge clk_in) disable iff (rst_in)
      accept && skip_pend_reg |=> left_reg == 2'h1;
   endproperty
   a_skip_one: assert property (p_skip_one)
      else $error("skip does not cost one machine cycle");

   property p_cycle_len;
      @(posedge clk_in) disable iff (rst_in)
      tick && processor_clock_control_in == 2'h0 |=> !tick [*3] ##1 tick;
   endproperty
   a_cycle_len: assert property (p_cycle_len)
      else $error("machine cycle length wrong");

   property p_fmem_area;
      @(posedge clk_in) disable iff (rst_in)
      commit && mem_we && (cur_reg.op == fsd_pkg::OP_SET1 ||
         cur_reg.op == fsd_pkg::OP_CLR1) |-> fmem_ok(cur_reg.addr);
   endproperty
   a_fmem_area: assert property (p_fmem_area)
      else $error("bit write outside special area");

   property p_jmp_area;
      @(posedge clk_in) disable iff (rst_in)
      commit && !skip_cur_reg && cur_reg.op == fsd_pkg::OP_JMP &&
         cur_reg.target > `FSD_PROG_TOP |=> pc_out == $past(pc_step) &&
         operand_fault_out;
   endproperty
   a_jmp_area: assert property (p_jmp_area)
      else $error("jump taken outside program area");

   property p_dir_area;
      @(posedge clk_in) disable iff (rst_in)
      commit && mem_we && cur_reg.op == fsd_pkg::OP_ST_A |-> dir_ok;
   endproperty
   a_dir_area: assert property (p_dir_area)
      else $error("direct store outside bank window");

   property p_no_port4;
      @(posedge clk_in) disable iff (rst_in)
      commit && !skip_cur_reg && cur_reg.op == fsd_pkg::OP_OUT &&
         cur_reg.port == `FSD_PORT_GAP |=>
         $stable(port_latch_out) && operand_fault_out;
   endproperty
   a_no_port4: assert property (p_no_port4)
      else $error("port 4 was written");

   property p_add_immediate_with_skip_carry;
      @(posedge clk_in) disable iff (rst_in)
      commit && !skip_cur_reg && cur_reg.op == fsd_pkg::OP_ADD_IMMEDIATE_WITH_SKIP |=>
         $stable(regs_out.carry_flag);
   endproperty
   a_add_immediate_with_skip_carry: assert property (p_add_immediate_with_skip_carry)
      else $error("add with skip changed carry");

   property p_add_immediate_with_skip_inhibit;
      @(posedge clk_in) disable iff (rst_in)
      commit && !skip_cur_reg && cur_reg.op == fsd_pkg::OP_ADD_IMMEDIATE_WITH_SKIP &&
         inhibit_reg |=> !skip_pending_out;
   endproperty
   a_add_immediate_with_skip_inhibit: assert property (p_add_immediate_with_skip_inhibit)
      else $error("correcting add caused a skip");
endmodule

// file: hw/fsd_defines.svh
`ifndef FSD_DEFINES_SVH
`define FSD_DEFINES_SVH
// Machine cycle length in clk_in periods for each clock control code
`define FSD_DIV_CODE0 4'h4
`define FSD_DIV_CODE1 4'h2
`define FSD_DIV_CODE2 4'h1
`define FSD_PCC_CODE0 2'h0
`define FSD_PCC_CODE1 2'h1
// Data memory banks and windows
`define FSD_BANK0 4'h0
`define FSD_BANK15 4'hF
`define FSD_B0_TOP 8'h3F
`define FSD_B15_BASE 8'h80
`define FSD_B15_OFS 8'h40
`define FSD_MEM_WORDS 192
`define FSD_FMEM_ROW_A 4'hB
`define FSD_FMEM_ROW_B 4'hF
// Program space and relative branch reach
`define FSD_PROG_TOP 11'h77F
`define FSD_REL_NEG_MIN 8'hF1
`define FSD_REL_POS_MIN 8'h02
`define FSD_REL_POS_MAX 8'h10
// Port numbering: no port 4
`define FSD_PORT_LOW_TOP 3'h3
`define FSD_PORT_GAP 3'h4
`define FSD_PORT_TOP 3'h6
// Cost of a skipped instruction in machine cycles
`define FSD_SKIP_CYCLES 2'h1
`endif

// file: hw/fsd_pkg.sv
package fsd_pkg;
   typedef enum logic [4:0] {
      OP_NOP, OP_MOV_A, OP_MOV_XA, OP_MOV_HL, OP_SEL_MB,
      OP_ADD_IMMEDIATE_WITH_SKIP, OP_ADD_WITH_CARRY_OP, OP_LD_A, OP_ST_A, OP_LD_XA,
      OP_SET1, OP_CLR1, OP_SKT, OP_SKF, OP_AND1, OP_OR1, OP_XOR1,
      OP_OUT, OP_IN, OP_EI, OP_DI, OP_JMP, OP_BR
   } fsd_op_t;

   // One decoded instruction as presented to the core
   typedef struct packed {
      fsd_op_t op;
      logic [7:0] imm;
      logic [1:0] bit_sel;
      logic [11:0] addr;
      logic [10:0] target;
      logic [2:0] port;
      logic [1:0] ie_sel;
      logic [1:0] bytes;
   } fsd_instr_t;

   // Programmer-visible register set
   typedef struct packed {
      logic [3:0] x;
      logic [3:0] a;
      logic [3:0] h;
      logic [3:0] l;
      logic carry_flag;
      logic [3:0] memory_bank_select;
   } fsd_regs_t;
endpackage

// file: tb/fsd_core_bench.sv
`timescale 1ns/100ps
module fsd_core_bench;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [1:0] rate = 2'h2;
   logic valid = 1'b0;
   fsd_pkg::fsd_instr_t instr = '0;
   logic [23:0] pins = 24'h000000;
   logic ready, fault, skip, tick;
   fsd_pkg::fsd_regs_t regs;
   logic [10:0] pc;
   logic [3:0] ena;
   logic [23:0] lat;
   int errors = 0;
   int tests_run = 0;
   // Reference model, starting from the reset state
   logic [3:0] mx = 4'h0, ma = 4'h0, mh = 4'h0, ml = 4'h0, mbank = 4'h0;
   logic mcar = 1'b0, mskip = 1'b0, mafter = 1'b0;
   logic [10:0] mpc = 11'h000;
   logic [3:0] mena = 4'h0;
   logic [23:0] mlat = 24'h000000;
   // Data memory is not reset, so every read follows a write
   logic [3:0] mem [int];
   logic [31:0] r;
   logic [11:0] a12;
   int g, c, i, d1, d2;
   fsd_pkg::fsd_op_t op;
   fsd_pkg::fsd_op_t rops [14] = '{fsd_pkg::OP_SET1, fsd_pkg::OP_CLR1,
      fsd_pkg::OP_SKT, fsd_pkg::OP_SKF, fsd_pkg::OP_AND1, fsd_pkg::OP_OR1,
      fsd_pkg::OP_XOR1, fsd_pkg::OP_MOV_A, fsd_pkg::OP_ST_A,
      fsd_pkg::OP_LD_A, fsd_pkg::OP_JMP, fsd_pkg::OP_BR, fsd_pkg::OP_ADD_IMMEDIATE_WITH_SKIP,
      fsd_pkg::OP_NOP};
   logic [7:0] lows [8] = '{8'h00, 8'h3F, 8'h40, 8'h7F, 8'h80, 8'h81,
      8'hFE, 8'hFF};
   logic [7:0] brs [8] = '{8'hF0, 8'hF1, 8'hFF, 8'h00, 8'h01, 8'h02,
      8'h10, 8'h11};
   int per [4] = '{4, 2, 1, 1};

   // 125 MHz clock
   always #4 clk_in = ~clk_in;

   fsd_core i_dut (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .processor_clock_control_in(rate),
      .instr_valid_in(valid),
      .instr_in(instr),
      .port_pins_in(pins),
      .instr_ready_out(ready),
      .regs_out(regs),
      .pc_out(pc),
      .ie_flags_out(ena),
      .port_latch_out(lat),
      .skip_pending_out(skip),
      .operand_fault_out(fault),
      .cycle_tick_out(tick)
   );

///////////////////////////////////////////////////////////////////////////////
   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input logic ok, input string what);
      tests_run++;
      if (ok !== 1'b1)
      begin
         errors++;
         $display("[FAIL] %0t ns: %s", $time, what);
      end
   endtask

   function automatic logic in_win(input logic [7:0] a8);
      return (mbank == 4'h0 && a8 <= 8'h3F) ||
         (mbank == 4'hF && a8 >= 8'h80);
   endfunction

   // Returns in the cycle where the tick is high
   task automatic wait_tick(output int gap);
      gap = 0;
      do
      begin
         @(posedge clk_in);
         #1;
         gap++;
      end while (tick !== 1'b1 && gap < 20);
   endtask

   // One instruction: offer, model it, wait for commit, compare all
   task automatic ex(input fsd_pkg::fsd_op_t op, input logic [7:0] imm,
      input logic [11:0] adr, input logic [2:0] sel, input logic [1:0] nb);
      logic skipped, bad;
      logic [4:0] sum;
      logic [10:0] npc;
      int key, idx, n, ticks, k;
      // Special bit operations carry their full address, bank included
      key = (op inside {fsd_pkg::OP_SET1, fsd_pkg::OP_CLR1, fsd_pkg::OP_SKT,
         fsd_pkg::OP_SKF, fsd_pkg::OP_AND1, fsd_pkg::OP_OR1,
         fsd_pkg::OP_XOR1}) ? int'(adr) : int'({mbank, adr[7:0]});
      idx = (sel < 3'h4) ? 4 * sel : 4 * sel - 4;
      chk(ready === 1'b1, "busy at request");
      instr = '{op, imm, sel[1:0], adr, adr[10:0], sel, sel[1:0], nb};
      valid = 1'b1;
      @(posedge clk_in);
      #1;
      valid = 1'b0;
      skipped = mskip;
      n = skipped ? 1 : int'(nb);
      npc = mpc + 11'(nb);
      case (op)
         fsd_pkg::OP_LD_A, fsd_pkg::OP_ST_A:
            bad = !in_win(adr[7:0]);
         fsd_pkg::OP_LD_XA: bad = !in_win(adr[7:0]) || adr[0];
         fsd_pkg::OP_SET1, fsd_pkg::OP_CLR1, fsd_pkg::OP_SKT,
         fsd_pkg::OP_SKF, fsd_pkg::OP_AND1, fsd_pkg::OP_OR1,
         fsd_pkg::OP_XOR1:
            bad = adr[11:4] != 8'hFB && adr[11:4] != 8'hFF;
         fsd_pkg::OP_OUT, fsd_pkg::OP_IN: bad = sel == 3'h4 || sel == 3'h7;
         fsd_pkg::OP_JMP: bad = adr[10:0] > 11'h77F;
         fsd_pkg::OP_BR: bad = (imm > 8'h10 && imm < 8'hF1) || imm < 8'h02;
         default: bad = 1'b0;
      endcase
      // A discarded instruction only moves the PC
      bad = bad && !skipped;
      mskip = 1'b0;
      if (!skipped && !bad)
      begin
         case (op)
            fsd_pkg::OP_MOV_A: ma = imm[3:0];
            fsd_pkg::OP_MOV_XA: {mx, ma} = imm;
            fsd_pkg::OP_MOV_HL: {mh, ml} = imm;
            fsd_pkg::OP_SEL_MB: mbank = imm[3:0];
            fsd_pkg::OP_ADD_IMMEDIATE_WITH_SKIP:
            begin
               sum = ma + imm[3:0];
               ma = sum[3:0];
               mskip = sum[4] && !mafter;
            end
            fsd_pkg::OP_ADD_WITH_CARRY_OP:
            begin
               sum = ma + mem[{mbank, mh, ml}] + mcar;
               {mcar, ma} = sum;
               mskip = sum[4];
            end
            fsd_pkg::OP_LD_A: ma = mem[key];
            fsd_pkg::OP_ST_A: mem[key] = ma;
            fsd_pkg::OP_LD_XA: {mx, ma} = {mem[key + 1], mem[key]};
            fsd_pkg::OP_SET1: mem[key][sel[1:0]] = 1'b1;
            fsd_pkg::OP_CLR1: mem[key][sel[1:0]] = 1'b0;
            fsd_pkg::OP_SKT: mskip = mem[key][sel[1:0]];
            fsd_pkg::OP_SKF: mskip = !mem[key][sel[1:0]];
            fsd_pkg::OP_AND1: mcar = mcar & mem[key][sel[1:0]];
            fsd_pkg::OP_OR1: mcar = mcar | mem[key][sel[1:0]];
            fsd_pkg::OP_XOR1: mcar = mcar ^ mem[key][sel[1:0]];
            fsd_pkg::OP_OUT: mlat[idx +: 4] = ma;
            fsd_pkg::OP_IN: ma = pins[idx +: 4];
            fsd_pkg::OP_EI: mena[sel[1:0]] = 1'b1;
            fsd_pkg::OP_DI: mena[sel[1:0]] = 1'b0;
            fsd_pkg::OP_JMP: npc = adr[10:0];
            fsd_pkg::OP_BR: npc = mpc + {{3{imm[7]}}, imm};
            default: ;
         endcase
      end
      mafter = op == fsd_pkg::OP_ADD_WITH_CARRY_OP && !skipped;
      mpc = npc;
      ticks = 0;
      k = 0;
      do
      begin
         ticks += (tick === 1'b1) ? 1 : 0;
         @(posedge clk_in);
         #1;
         k++;
      end while (ready !== 1'b1 && k < 40);
      if (k >= 40)
      begin
         chk(1'b0, "no completion");
         wrap_up();
      end
      chk(ticks == n, "machine cycles");
      chk(regs === {mx, ma, mh, ml, mcar, mbank}, "registers");
      chk(pc === mpc, "program counter");
      chk(fault === bad && skip === mskip, "fault or skip");
      chk({ena, lat} === {mena, mlat}, "enables or latches");
   endtask

   task automatic mv(input fsd_pkg::fsd_op_t op, input logic [7:0] imm);
      ex(op, imm, 12'h000, 3'h0, 2'h1);
   endtask

   task automatic mm(input fsd_pkg::fsd_op_t op, input logic [11:0] adr);
      ex(op, 8'h00, adr, 3'h0, 2'h1);
   endtask

///////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      void'($urandom(88252));
      r = $urandom;
      pins = r[23:0];
      repeat (12) @(posedge clk_in);
      #1;
      rst_in = 1'b0;
      chk(regs === '0 && pc === 11'h000 && {ena, lat, skip, fault} === '0
         && ready === 1'b1, "reset state");
      // New rate applies from the next tick, so the third gap is measured
      for (c = 0; c < 4; c++)
      begin
         rate = c[1:0];
         wait_tick(g);
         wait_tick(g);
         wait_tick(g);
         chk(g == per[c], "tick spacing");
      end
      rate = 2'h2;
      // Moves, every port code including the missing one, enable flags
      for (c = 0; c < 8; c++)
      begin
         r = $urandom;
         mv(fsd_pkg::OP_MOV_XA, r[7:0]);
         mv(fsd_pkg::OP_MOV_HL, r[15:8]);
         ex(fsd_pkg::OP_OUT, 8'h00, 12'h000, c[2:0], 2'h1);
         ex(fsd_pkg::OP_IN, 8'h00, 12'h000, c[2:0], 2'h1);
         op = c[2] ? fsd_pkg::OP_DI : fsd_pkg::OP_EI;
         ex(op, 8'h00, 12'h000, c[2:0], 2'h1);
      end
      // Window edges of both banks
      for (c = 0; c < 16; c++)
      begin
         r = $urandom;
         a12 = {4'h0, lows[c[2:0]]};
         mv(fsd_pkg::OP_SEL_MB, c[3] ? 8'h0F : 8'h00);
         mv(fsd_pkg::OP_MOV_A, r[7:0]);
         mm(fsd_pkg::OP_ST_A, a12);
         mv(fsd_pkg::OP_MOV_A, r[15:8]);
         mm(fsd_pkg::OP_LD_A, a12);
      end
      mm(fsd_pkg::OP_LD_XA, 12'h080);
      mm(fsd_pkg::OP_LD_XA, 12'h081);
      mm(fsd_pkg::OP_LD_XA, 12'h0FE);
      for (c = 0; c < 16; c++)
      begin
         r = $urandom;
         mv(fsd_pkg::OP_MOV_A, r[7:0]);
         mm(fsd_pkg::OP_ST_A, 12'hFB0 + 12'(c));
      end
      // Random bit, skip and jump mix at random rates
      for (i = 0; i < 80; i++)
      begin
         r = $urandom;
         rate = r[1:0];
         op = rops[r[7:4] % 14];
         a12 = {8'hFB, r[3:0]};
         if (op == fsd_pkg::OP_JMP)
            a12 = {1'b0, r[18:8]};
         else if (r[10:8] == 3'h0 && op inside {fsd_pkg::OP_AND1,
            fsd_pkg::OP_OR1, fsd_pkg::OP_XOR1})
            a12 = 12'hF80;
         ex(op, r[31:24], a12, r[14:12], r[15] ? 2'h2 : 2'h1);
      end
      mv(fsd_pkg::OP_NOP, 8'h00);
      for (c = 0; c < 8; c++)
         mv(fsd_pkg::OP_BR, brs[c]);
      mm(fsd_pkg::OP_JMP, 12'h77F);
      mm(fsd_pkg::OP_JMP, 12'h780);
      // Decimal add at HL; carry cleared by AND with a zero bit
      mv(fsd_pkg::OP_MOV_HL, 8'h90);
      for (c = 0; c < 12; c++)
      begin
         r = $urandom;
         d1 = (c == 0) ? 9 : r[7:0] % 10;
         d2 = (c == 0) ? 9 : r[15:8] % 10;
         mv(fsd_pkg::OP_MOV_A, 8'(d2));
         mm(fsd_pkg::OP_ST_A, 12'hF90);
         mm(fsd_pkg::OP_CLR1, 12'hFB0);
         mm(fsd_pkg::OP_AND1, 12'hFB0);
         mv(fsd_pkg::OP_MOV_A, 8'(d1));
         mv(fsd_pkg::OP_ADD_IMMEDIATE_WITH_SKIP, 8'h06);
         mv(fsd_pkg::OP_ADD_WITH_CARRY_OP, 8'h00);
         mv(fsd_pkg::OP_ADD_IMMEDIATE_WITH_SKIP, 8'h0A);
         d1 = d1 + d2 + ((d1 + d2 > 9) ? 6 : 0);
         chk({regs.carry_flag, regs.a} === 5'(d1), "decimal sum");
      end
      wrap_up();
   end
endmodule
